// >>> qhp_defines.svh
`ifndef QHP_DEFINES_SVH
`define QHP_DEFINES_SVH

// ------------------------------------------------------------
// device register file
// ------------------------------------------------------------
`define QHP_MODEM_CTRL_ADDR 3'h4
`define QHP_IRQ_OUT_EN_BIT  3
`define QHP_REG_RESET       8'h00

// ------------------------------------------------------------
// host command port map
// ------------------------------------------------------------
`define QHP_HOST_CFG        2'h0
`define QHP_HOST_CMD        2'h1
`define QHP_HOST_DATA       2'h2
`define QHP_HOST_STATUS     2'h3
`define QHP_CFG_STYLE_BIT   0
`define QHP_CFG_CONTSEL_BIT 1
`define QHP_CMD_CHAN_LSB    3
`define QHP_CMD_REG_LSB     0
`define QHP_CMD_DIR_BIT     7

// ------------------------------------------------------------
// host bus cycle timing in clk cycles
// ------------------------------------------------------------
`define QHP_SETUP_CYC       4'h2
`define QHP_STROBE_CYC      4'h8
`define QHP_HOLD_CYC        4'h4

`endif

// >>> qhp_pkg.sv
`default_nettype none
package qhp_pkg;
	typedef enum logic [1:0] {
		HST_IDLE,
		HST_SETUP,
		HST_STROBE,
		HST_HOLD
	} qhp_host_state_e;
	typedef logic [7:0] qhp_byte_t;
endpackage
`default_nettype wire

// >>> qhp_bus_if.sv
`timescale 1ns/100ps
`default_nettype none
// pin-level host bus between controller and quad uart port
interface qhp_bus_if;
	logic       bus_style_sel;     // 1 strobe style, 0 rw-line style
	logic       irq_continuous_select;
	logic [2:0] reg_addr;          // reg_addr_bit2..reg_addr_bit0
	logic       read_strobe_n;
	logic       write_strobe_n;    // direction line in rw-line style
	logic [3:0] chan_select_n;     // chan0..chan3 selects
	logic [7:0] host_data_out;
	logic       host_data_oe_n;
	logic [7:0] dev_data_out;
	logic       dev_data_oe_n;
	logic [3:0] irq_out;           // chan0_irq_out..chan3_irq_out
	logic [3:0] irq_oe_n;
	logic [7:0] data_bus;          // resolved data_bus_msb..data_bus_lsb
	logic [3:0] irq_level;         // resolved interrupt wires

	// ------------------------------------------------------------
	// wire resolution: undriven data floats high, chan0 has pull-up
	// ------------------------------------------------------------
	assign data_bus = !host_data_oe_n ? host_data_out :
	                  !dev_data_oe_n  ? dev_data_out  : 8'hff;
	assign irq_level[0] = irq_oe_n[0] ? 1'b1 : irq_out[0];
	assign irq_level[3:1] = irq_out[3:1] & ~irq_oe_n[3:1];

	modport dev (
		input  bus_style_sel, irq_continuous_select, reg_addr, read_strobe_n,
		input  write_strobe_n, chan_select_n, data_bus,
		output dev_data_out, dev_data_oe_n, irq_out, irq_oe_n
	);
	modport host (
		output bus_style_sel, irq_continuous_select, reg_addr, read_strobe_n,
		output write_strobe_n, chan_select_n, host_data_out, host_data_oe_n,
		input  data_bus, irq_level
	);
endinterface
`default_nettype wire

// >>> qhp_dev.sv
// Overview of operation
// - style pin high strobes, low rw-line
// - three address bits pick channel register
// - 8-bit data bus, device drives reads
// - read strobe fall starts internal read
// - device places byte; host captures rising
// - rw-line style: host holds read strobe high
// - write strobe fall starts internal write
// - write strobe rise stores bus byte
// - rw-line: direction 1 read, 0 write
// - strobe style: per-channel active-low selects
// - rw-line: first select is device select
// - rw-line: selects two, three pick channel
// - rw-line: host ties fourth select high
// - strobe style: enable bit drives chan0 irq
// - enable bit clear: chan0 irq floats, default
// - rw-line: chan0 irq open-drain active low
// - other irqs follow enable; rw-line zero
// - strobe style: irq select high forces irqs enabled
`timescale 1ns/100ps
`default_nettype none
`include "qhp_defines.svh"
module qhp_dev (
	input  wire logic         clk,
	input  wire logic         srst,
	qhp_bus_if.dev            bus,
	input  wire logic [3:0]   chan_irq_req,
	output logic              rd_pulse,
	output logic              wr_pulse,
	output logic [1:0]        acc_chan,
	output logic [2:0]        acc_addr,
	output logic [7:0]        wr_data
);
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic       style_m_q, style_s_q;
	logic       csel_m_q, csel_s_q;
	logic       rd_m_q, rd_s_q;
	logic       wr_m_q, wr_s_q;
	logic [3:0] cs_m_q, cs_s_q;
	logic [2:0] addr_m_q, addr_s_q;
	logic [7:0] data_m_q, data_s_q;

	// two flops on every pin from the host
	always_ff @(posedge clk) begin
		if (srst) begin
			style_m_q  <= 1'b1;
			style_s_q  <= 1'b1;
			csel_m_q   <= 1'b0;
			csel_s_q   <= 1'b0;
			rd_m_q     <= 1'b1;
			rd_s_q     <= 1'b1;
			wr_m_q     <= 1'b1;
			wr_s_q     <= 1'b1;
			cs_m_q     <= 4'hf;
			cs_s_q     <= 4'hf;
			addr_m_q   <= 3'h0;
			addr_s_q   <= 3'h0;
			data_m_q   <= 8'h00;
			data_s_q   <= 8'h00;
		end else begin
			style_m_q  <= bus.bus_style_sel;
			style_s_q  <= style_m_q;
			csel_m_q   <= bus.irq_continuous_select;
			csel_s_q   <= csel_m_q;
			rd_m_q     <= bus.read_strobe_n;
			rd_s_q     <= rd_m_q;
			wr_m_q     <= bus.write_strobe_n;
			wr_s_q     <= wr_m_q;
			cs_m_q     <= bus.chan_select_n;
			cs_s_q     <= cs_m_q;
			addr_m_q   <= bus.reg_addr;
			addr_s_q   <= addr_m_q;
			data_m_q   <= bus.data_bus;
			data_s_q   <= data_m_q;
		end
	end

	// ------------------------------------------------------------
	// bus cycle decode
	// ------------------------------------------------------------
	logic       sel_any;
	logic [1:0] chan_now;
	logic       act_now;
	logic       is_read;

	// strobe style picks the lowest asserted select
	always_comb begin
		sel_any  = ~&cs_s_q;
		chan_now = 2'h0;
		if (style_s_q) begin
			if (!cs_s_q[0])
				chan_now = 2'h0;
			else if (!cs_s_q[1])
				chan_now = 2'h1;
			else if (!cs_s_q[2])
				chan_now = 2'h2;
			else
				chan_now = 2'h3;
		end else begin
			chan_now = {cs_s_q[2], cs_s_q[1]};
		end
		if (style_s_q) begin
			act_now = (~rd_s_q | ~wr_s_q) & sel_any;
			is_read = ~rd_s_q;
		end else begin
			act_now = ~cs_s_q[0];
			is_read = wr_s_q;
		end
	end

	// ------------------------------------------------------------
	// cycle tracking
	// ------------------------------------------------------------
	logic       act_q;
	logic       cyc_rd_q;
	logic [1:0] cyc_ch_q;
	logic       start_ev;
	logic       end_ev;

	assign start_ev = act_now & ~act_q;
	assign end_ev   = ~act_now & act_q;

	// remember direction and channel of the running cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			act_q    <= 1'b0;
			cyc_rd_q <= 1'b0;
			cyc_ch_q <= 2'h0;
		end else begin
			act_q <= act_now;
			if (start_ev) begin
				cyc_rd_q <= is_read;
				cyc_ch_q <= chan_now;
			end
		end
	end

	// ------------------------------------------------------------
	// register file: four channels of eight bytes
	// ------------------------------------------------------------
	logic [7:0] regs_q [0:3][0:7];
	logic [3:0] irq_en;

	// bytes are stored when the write strobe or device select rises
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int c = 0; c < 4; c++) begin
				for (int r = 0; r < 8; r++) begin
					regs_q[c][r] <= `QHP_REG_RESET;
				end
			end
		end else if (end_ev && !cyc_rd_q) begin
			regs_q[cyc_ch_q][addr_s_q] <= data_s_q;
		end
	end

	// interrupt enable bit of each channel's modem control register
	always_comb begin
		for (int c = 0; c < 4; c++) begin
			irq_en[c] = regs_q[c][`QHP_MODEM_CTRL_ADDR][`QHP_IRQ_OUT_EN_BIT];
		end
	end

	// ------------------------------------------------------------
	// read data drive
	// ------------------------------------------------------------
	logic [7:0] dout_q;
	logic       doe_n_q;

	// byte fetched at read start, driven until the cycle ends
	always_ff @(posedge clk) begin
		if (srst) begin
			dout_q  <= 8'h00;
			doe_n_q <= 1'b1;
		end else if (start_ev && is_read) begin
			dout_q  <= regs_q[chan_now][addr_s_q];
			doe_n_q <= 1'b0;
		end else if (!act_now) begin
			doe_n_q <= 1'b1;
		end
	end

	assign bus.dev_data_out  = dout_q;
	assign bus.dev_data_oe_n = doe_n_q;

	// ------------------------------------------------------------
	// user side event outputs
	// ------------------------------------------------------------
	logic       rd_pulse_q;
	logic       wr_pulse_q;
	logic [1:0] acc_chan_q;
	logic [2:0] acc_addr_q;
	logic [7:0] wr_data_q;

	// one-cycle notices of internal reads and writes
	always_ff @(posedge clk) begin
		if (srst) begin
			rd_pulse_q <= 1'b0;
			wr_pulse_q <= 1'b0;
			acc_chan_q <= 2'h0;
			acc_addr_q <= 3'h0;
			wr_data_q  <= 8'h00;
		end else begin
			rd_pulse_q <= start_ev & is_read;
			wr_pulse_q <= end_ev & ~cyc_rd_q;
			if (start_ev && is_read) begin
				acc_chan_q <= chan_now;
				acc_addr_q <= addr_s_q;
			end else if (end_ev && !cyc_rd_q) begin
				acc_chan_q <= cyc_ch_q;
				acc_addr_q <= addr_s_q;
				wr_data_q  <= data_s_q;
			end
		end
	end

	assign rd_pulse = rd_pulse_q;
	assign wr_pulse = wr_pulse_q;
	assign acc_chan = acc_chan_q;
	assign acc_addr = acc_addr_q;
	assign wr_data  = wr_data_q;

	// ------------------------------------------------------------
	// interrupt pins
	// ------------------------------------------------------------
	logic [3:0] irq_q;
	logic [3:0] irq_oe_n_q;

	// per-channel drive control, one lane each
	for (genvar i = 0; i < 4; i++) begin : g_irq
		always_ff @(posedge clk) begin
			if (srst) begin
				irq_q[i]      <= 1'b0;
				irq_oe_n_q[i] <= 1'b1;
			end else if (style_s_q) begin
				irq_q[i]      <= chan_irq_req[i];
				irq_oe_n_q[i] <= ~(irq_en[i] | csel_s_q);
			end else if (i == 0) begin
				irq_q[i]      <= 1'b0;
				irq_oe_n_q[i] <= ~|chan_irq_req;
			end else begin
				irq_q[i]      <= 1'b0;
				irq_oe_n_q[i] <= 1'b0;
			end
		end
	end

	assign bus.irq_out  = irq_q;
	assign bus.irq_oe_n = irq_oe_n_q;

endmodule
`default_nettype wire

// >>> qhp_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "qhp_defines.svh"
module qhp_host (
	input  wire logic         clk,
	input  wire logic         srst,
	qhp_bus_if.host           bus,
	input  wire logic [1:0]   cmd_addr,
	input  wire logic [7:0]   cmd_wdata,
	input  wire logic         cmd_wr,
	input  wire logic         cmd_rd,
	output logic [7:0]        cmd_rdata
);
	qhp_pkg::qhp_host_state_e st_q;
	logic [3:0]        cnt_q;
	logic              style_q, csel_q;
	logic [7:0]        cmd_q, wdata_q, rdata_q, cmd_rdata_q;
	logic [7:0]        dm_q, ds_q;
	logic [3:0]        im_q, is_q;
	logic              rd_n_q, wr_n_q, doe_n_q;
	logic [3:0]        cs_n_q;
	logic [2:0]        addr_q;
	logic              go;
	logic              dir_rd;

	assign go     = cmd_wr && cmd_addr == `QHP_HOST_CMD && st_q == qhp_pkg::HST_IDLE;
	assign dir_rd = cmd_q[`QHP_CMD_DIR_BIT];

	// ------------------------------------------------------------
	// command registers and read port
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			style_q     <= 1'b1;
			csel_q      <= 1'b0;
			cmd_q       <= 8'h00;
			wdata_q     <= 8'h00;
			cmd_rdata_q <= 8'h00;
		end else begin
			if (cmd_wr && cmd_addr == `QHP_HOST_CFG) begin
				style_q  <= cmd_wdata[`QHP_CFG_STYLE_BIT];
				csel_q   <= cmd_wdata[`QHP_CFG_CONTSEL_BIT];
			end
			if (go)
				cmd_q <= cmd_wdata;
			if (cmd_wr && cmd_addr == `QHP_HOST_DATA)
				wdata_q <= cmd_wdata;
			cmd_rdata_q <= 8'h00;
			if (cmd_rd) begin
				case (cmd_addr)
					`QHP_HOST_CFG:  cmd_rdata_q <= {6'h00, csel_q, style_q};
					`QHP_HOST_CMD:  cmd_rdata_q <= cmd_q;
					`QHP_HOST_DATA: cmd_rdata_q <= rdata_q;
					default:        cmd_rdata_q <= {is_q, 3'h0, st_q != qhp_pkg::HST_IDLE};
				endcase
			end
		end
	end

	assign cmd_rdata = cmd_rdata_q;

	// two flops on data and interrupt wires from the device
	always_ff @(posedge clk) begin
		if (srst) begin
			dm_q <= 8'h00;
			ds_q <= 8'h00;
			im_q <= 4'h0;
			is_q <= 4'h0;
		end else begin
			dm_q <= bus.data_bus;
			ds_q <= dm_q;
			im_q <= bus.irq_level;
			is_q <= im_q;
		end
	end

	// ------------------------------------------------------------
	// bus cycle sequencer: setup, strobe, hold
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (srst) begin
			st_q    <= qhp_pkg::HST_IDLE;
			cnt_q   <= 4'h0;
			rdata_q <= 8'h00;
			rd_n_q  <= 1'b1;
			wr_n_q  <= 1'b1;
			cs_n_q  <= 4'hf;
			addr_q  <= 3'h0;
			doe_n_q <= 1'b1;
		end else begin
			case (st_q)
				qhp_pkg::HST_IDLE: begin
					if (go) begin
						addr_q  <= cmd_wdata[`QHP_CMD_REG_LSB +: 3];
						doe_n_q <= cmd_wdata[`QHP_CMD_DIR_BIT];
						if (style_q) begin
							cs_n_q <= ~(4'h1 << cmd_wdata[`QHP_CMD_CHAN_LSB +: 2]);
						end else begin
							cs_n_q <= {1'b1, cmd_wdata[`QHP_CMD_CHAN_LSB +: 2], 1'b1};
							wr_n_q <= cmd_wdata[`QHP_CMD_DIR_BIT];
						end
						cnt_q <= `QHP_SETUP_CYC;
						st_q  <= qhp_pkg::HST_SETUP;
					end
				end
				qhp_pkg::HST_SETUP: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h1) begin
						if (!style_q)
							cs_n_q[0] <= 1'b0;
						else if (dir_rd)
							rd_n_q <= 1'b0;
						else
							wr_n_q <= 1'b0;
						cnt_q <= `QHP_STROBE_CYC;
						st_q  <= qhp_pkg::HST_STROBE;
					end
				end
				qhp_pkg::HST_STROBE: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h1) begin
						if (dir_rd)
							rdata_q <= ds_q;
						if (style_q) begin
							rd_n_q <= 1'b1;
							wr_n_q <= 1'b1;
						end else begin
							cs_n_q[0] <= 1'b1;
						end
						cnt_q <= `QHP_HOLD_CYC;
						st_q  <= qhp_pkg::HST_HOLD;
					end
				end
				qhp_pkg::HST_HOLD: begin
					cnt_q <= cnt_q - 4'h1;
					if (cnt_q == 4'h1) begin
						cs_n_q  <= 4'hf;
						wr_n_q  <= 1'b1;
						doe_n_q <= 1'b1;
						st_q    <= qhp_pkg::HST_IDLE;
					end
				end
				default: st_q <= qhp_pkg::HST_IDLE;
			endcase
		end
	end

	assign bus.bus_style_sel         = style_q;
	assign bus.irq_continuous_select = csel_q & style_q;
	assign bus.reg_addr              = addr_q;
	assign bus.read_strobe_n         = rd_n_q;
	assign bus.write_strobe_n        = wr_n_q;
	assign bus.chan_select_n         = cs_n_q;
	assign bus.host_data_out         = wdata_q;
	assign bus.host_data_oe_n        = doe_n_q;

endmodule
`default_nettype wire

// >>> qhp_sva.sv
`timescale 1ns/100ps
`default_nettype none
module qhp_sva (
	input wire logic       clk,
	input wire logic       srst,
	input wire logic       bus_style_sel,
	input wire logic       irq_continuous_select,
	input wire logic       read_strobe_n,
	input wire logic       write_strobe_n,
	input wire logic [3:0] chan_select_n,
	input wire logic       host_data_oe_n,
	input wire logic       dev_data_oe_n,
	input wire logic [3:0] irq_out,
	input wire logic [3:0] irq_oe_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	logic sel_any;
	// ------------------------------------------------------------
	// a bus cycle is open, in either style
	// ------------------------------------------------------------
	assign sel_any = bus_style_sel ? (chan_select_n != 4'hf) : !chan_select_n[0];
	property p_idle_float; (!sel_any) [*4] |-> dev_data_oe_n; endproperty
	a_idle_float: assert property (p_idle_float) else $error("data driven outside cycle");
	property p_wr_quiet; (bus_style_sel && !write_strobe_n) [*4] |-> dev_data_oe_n; endproperty
	a_wr_quiet: assert property (p_wr_quiet) else $error("data driven in write");
	property p_rd_drive;
		(bus_style_sel && !read_strobe_n && chan_select_n != 4'hf) [*4] |-> !dev_data_oe_n;
	endproperty
	a_rd_drive: assert property (p_rd_drive) else $error("read byte not driven");
	property p_rw_rd_drive;
		(!bus_style_sel && !chan_select_n[0] && write_strobe_n) [*4] |-> !dev_data_oe_n;
	endproperty
	a_rw_rd_drive: assert property (p_rw_rd_drive) else $error("rw read not driven");
	property p_no_clash; !dev_data_oe_n |-> host_data_oe_n; endproperty
	a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
	property p_rst_quiet;
		@(posedge clk) disable iff (1'b0) srst |=> irq_oe_n == 4'hf && dev_data_oe_n;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("pins driven after reset");
	property p_csel_on;
		(bus_style_sel && irq_continuous_select) [*4] |-> irq_oe_n == 4'h0;
	endproperty
	a_csel_on: assert property (p_csel_on) else $error("irq not forced on");
	property p_rw_irq_low;
		(!bus_style_sel) [*4] |-> irq_oe_n[3:1] == 3'h0 && irq_out[3:1] == 3'h0;
	endproperty
	a_rw_irq_low: assert property (p_rw_irq_low) else $error("upper irqs not low");
	property p_rw_irq0_od; (!bus_style_sel) [*4] |-> irq_oe_n[0] || !irq_out[0]; endproperty
	a_rw_irq0_od: assert property (p_rw_irq0_od) else $error("shared irq drives high");
	property p_rw_unused; !bus_style_sel |-> read_strobe_n && chan_select_n[3]; endproperty
	a_rw_unused: assert property (p_rw_unused) else $error("unused inputs not high");
	// ------------------------------------------------------------
	// main scenarios reached
	// ------------------------------------------------------------
	c_rd: cover property ((bus_style_sel && !read_strobe_n) [*4]);
	c_rw_rd: cover property ((!bus_style_sel && !chan_select_n[0] && write_strobe_n) [*4]);
	c_csel: cover property ((bus_style_sel && irq_continuous_select) [*4]);
endmodule
`default_nettype wire

// >>> test_quad_uart_host_bus_port.sv
`timescale 1ns/100ps
`default_nettype none
`include "qhp_defines.svh"
module test_quad_uart_host_bus_port;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic [3:0] chan_irq_req = 4'h0;
	logic [1:0] cmd_addr = 2'h0;
	logic [7:0] cmd_wdata = 8'h00;
	logic       cmd_wr = 1'b0;
	logic       cmd_rd = 1'b0;
	logic [7:0] cmd_rdata;
	logic       rd_pulse;
	logic       wr_pulse;
	logic [1:0] acc_chan;
	logic [2:0] acc_addr;
	logic [7:0] wr_data;
	int         bad_count = 0;
	int         samples_checked = 0;
	int         wr_seen = 0;
	int         rd_seen = 0;
	qhp_bus_if i_qhp_bus_if ();
	qhp_dev i_qhp_dev (.clk(clk), .srst(srst), .bus(i_qhp_bus_if.dev), .chan_irq_req(chan_irq_req),
		.rd_pulse(rd_pulse), .wr_pulse(wr_pulse), .acc_chan(acc_chan), .acc_addr(acc_addr),
		.wr_data(wr_data));
	qhp_host i_qhp_host (.clk(clk), .srst(srst), .bus(i_qhp_bus_if.host), .cmd_addr(cmd_addr),
		.cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_rdata(cmd_rdata));
	qhp_sva i_qhp_sva (.clk(clk), .srst(srst), .bus_style_sel(i_qhp_bus_if.bus_style_sel),
		.irq_continuous_select(i_qhp_bus_if.irq_continuous_select),
		.read_strobe_n(i_qhp_bus_if.read_strobe_n), .write_strobe_n(i_qhp_bus_if.write_strobe_n),
		.chan_select_n(i_qhp_bus_if.chan_select_n), .host_data_oe_n(i_qhp_bus_if.host_data_oe_n),
		.dev_data_oe_n(i_qhp_bus_if.dev_data_oe_n), .irq_out(i_qhp_bus_if.irq_out),
		.irq_oe_n(i_qhp_bus_if.irq_oe_n));
	// clock and pulse counters
	always #10 clk = ~clk;
	always @(posedge clk) begin
		if (wr_pulse) wr_seen <= wr_seen + 1;
		if (rd_pulse) rd_seen <= rd_seen + 1;
	end
	// ------------------------------------------------------------
	// command port access and comparison
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic cmd_write(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		cmd_addr <= a;
		cmd_wdata <= d;
		cmd_wr <= 1'b1;
		@(posedge clk);
		cmd_wr <= 1'b0;
	endtask
	task automatic cmd_read(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk);
		cmd_addr <= a;
		cmd_rd <= 1'b1;
		@(posedge clk);
		cmd_rd <= 1'b0;
		#1 d = cmd_rdata;
	endtask
	// one pin-level transfer, then wait for the controller to go idle
	task automatic xfer(input logic rd, input logic [1:0] ch, input logic [2:0] ra,
		input logic [7:0] d);
		logic [7:0] s;
		cmd_write(`QHP_HOST_DATA, d);
		cmd_write(`QHP_HOST_CMD, {rd, 2'h0, ch, ra});
		s = 8'h01;
		for (int i = 0; i < 40 && s[0] !== 1'b0; i++) cmd_read(`QHP_HOST_STATUS, s);
		chk("busy", 8'h00, {7'h0, s[0]});
		repeat (4) @(posedge clk);
	endtask
	// interrupt wires seen directly and through the synced status bits
	task automatic irq_check(input logic [3:0] exp);
		logic [7:0] s;
		repeat (8) @(posedge clk);
		chk("irq_level", {4'h0, exp}, {4'h0, i_qhp_bus_if.irq_level});
		cmd_read(`QHP_HOST_STATUS, s);
		chk("status_irq", {4'h0, exp}, {4'h0, s[7:4]});
	endtask
	task automatic complete_run;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// watchdog against a hung handshake
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		$display("[ERR] run_end expected done seen hang");
		complete_run;
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [7:0] d;
		logic [7:0] img [8];
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		// strobe style: write each of the eight addresses once, channel from the low address bits
		for (int r = 0; r < 8; r++) begin
			img[r] = 8'ha0 | 8'(r);
			xfer(1'b0, 2'(r), 3'(r), img[r]);
			chk("wr_count", 8'(r + 1), 8'(wr_seen));
			chk("wr_chan", 8'(r % 4), {6'h0, acc_chan});
			chk("wr_addr", 8'(r), {5'h0, acc_addr});
			chk("wr_data", img[r], wr_data);
		end
		// read back in reverse order
		for (int r = 7; r >= 0; r--) begin
			xfer(1'b1, 2'(r), 3'(r), 8'h00);
			chk("rd_chan", 8'(r % 4), {6'h0, acc_chan});
			chk("rd_addr", 8'(r), {5'h0, acc_addr});
			cmd_read(`QHP_HOST_DATA, d);
			chk("rd_byte", img[r], d);
		end
		chk("rd_count", 8'h08, 8'(rd_seen));
		// strobe style interrupts: float, per-channel enable, continuous select
		@(posedge clk);
		chan_irq_req <= 4'hf;
		irq_check(4'h1);
		xfer(1'b0, 2'h1, `QHP_MODEM_CTRL_ADDR, 8'h08);
		irq_check(4'h3);
		cmd_write(`QHP_HOST_CFG, 8'h03);
		irq_check(4'hf);
		@(posedge clk);
		chan_irq_req <= 4'h0;
		irq_check(4'h0);
		// read/write-line style: shared open-drain interrupt
		cmd_write(`QHP_HOST_CFG, 8'h00);
		irq_check(4'h1);
		@(posedge clk);
		chan_irq_req <= 4'h4;
		irq_check(4'h0);
		for (int c = 0; c < 4; c++) begin
			xfer(1'b0, 2'(c), 3'h6, 8'h3c ^ 8'(c));
			chk("rw_wr_chan", 8'(c), {6'h0, acc_chan});
			chk("rw_wr_data", 8'h3c ^ 8'(c), wr_data);
			xfer(1'b1, 2'(c), 3'h6, 8'h00);
			cmd_read(`QHP_HOST_DATA, d);
			chk("rw_rd_byte", 8'h3c ^ 8'(c), d);
		end
		// a byte stored in strobe style reads back in read/write-line style
		xfer(1'b1, 2'h3, 3'h7, 8'h00);
		cmd_read(`QHP_HOST_DATA, d);
		chk("style_cross", img[7], d);
		complete_run;
	end
endmodule
`default_nettype wire
